// ===== rtl/gct_pkg.sv
// Constants, encodings and types shared by the gated counter/timer.
package gct_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] GCT_CTRL_OFS  = 8'h00;
    localparam logic [7:0] GCT_CMD_OFS   = 8'h04;
    localparam logic [7:0] GCT_STAT_OFS  = 8'h08;
    localparam logic [7:0] GCT_RES_OFS   = 8'h0c;
    localparam logic [7:0] GCT_ISTAT_OFS = 8'h10;
    localparam logic [7:0] GCT_IMASK_OFS = 8'h14;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int GCT_FUNC_LSB = 0;
    localparam int GCT_HOLD_BIT = 3;
    localparam int GCT_GSEL_LSB = 4;
    localparam int GCT_CMD_CLR  = 0;
    localparam int GCT_CMD_ARM  = 1;
    localparam int GCT_IRQ_DONE = 0;
    localparam int GCT_IRQ_OVF  = 1;
    localparam logic [2:0] GCT_GSEL_MAX = 3'h4;
    localparam logic [2:0] GCT_GSEL_RST = 3'h4;
    localparam logic       GCT_HOLD_RST = 1'b0;

    // ------------------------------------------------------------
    // Measurement functions
    // ------------------------------------------------------------
    localparam logic [2:0] GCT_F_FREQ  = 3'h0;
    localparam logic [2:0] GCT_F_PER   = 3'h1;
    localparam logic [2:0] GCT_F_AVG   = 3'h2;
    localparam logic [2:0] GCT_F_PULSE = 3'h3;
    localparam logic [2:0] GCT_F_GATED = 3'h4;
    localparam logic [2:0] GCT_F_FREE  = 3'h5;
    localparam logic [2:0] GCT_FUNC_RST = GCT_F_FREQ;

    // ------------------------------------------------------------
    // Counts, times and result exponents
    // ------------------------------------------------------------
    localparam int GCT_DIGITS = 8;
    localparam int GCT_MANT_W = 27;
    localparam logic [26:0] GCT_CNT_MAX = 27'd99999999;
    localparam int GCT_CLK_NS = 4;
    localparam int GCT_GATE_MIN_US = 100;
    localparam int GCT_GATE_MIN_CYC = GCT_GATE_MIN_US * 1000 / GCT_CLK_NS;
    localparam int GCT_PER_RES_NS = 100;
    localparam int GCT_PER_TICK_CYC = GCT_PER_RES_NS / GCT_CLK_NS;
    localparam logic [26:0] GCT_PW_LIM = 27'(GCT_CNT_MAX / GCT_CLK_NS);
    localparam logic [26:0] GCT_AVG_SCALE = 27'd10000;
    localparam logic [4:0] GCT_EXP_PER = 5'h19;
    localparam logic [4:0] GCT_EXP_AVG = 5'h18;
    localparam logic [4:0] GCT_EXP_PW  = 5'h17;
    localparam logic [4:0] GCT_EXP_TOT = 5'h00;
    localparam logic [4:0] GCT_DIV_LAST = 5'h1a;

    typedef enum logic [1:0] {
        GCT_ARMED,
        GCT_MEAS,
        GCT_DIV,
        GCT_DONE
    } gct_state_t;

endpackage

// ===== rtl/gct_top.sv
// Gated counter/timer with an APB register file and interrupt.
//
// Register access over APB and the register offsets were left to the implementer.
module gct_top
    import gct_pkg::*;
#(
    parameter int unsigned GATE_MIN_CYC_P = GCT_GATE_MIN_CYC
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Measured signal and interrupt
    input  wire logic        sig_in,
    output logic             irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    gct_state_t  state_reg;
    logic [2:0]  func_reg, gsel_reg;
    logic        hold_reg, sig_d_reg, valid_reg, ovf_reg, wait_reg;
    logic [26:0] cnt_reg, q_reg, rem_reg;
    logic [31:0] tmr_reg, res_reg, prdata_reg;
    logic [4:0]  dcnt_reg;
    logic [1:0]  istat_reg, imask_reg;

    logic        access, wr, restart, arm_cmd, stall, unmapped, rise, fall;
    logic        tick, step, fin, ovf_set, div_ge;
    logic [31:0] rdata, gate_len;
    logic [26:0] dec10, fin_mant, lim;
    logic [4:0]  fin_exp;
    logic [27:0] div_r;
    logic [1:0]  evt;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign access   = psel & penable;
    assign wr       = access & pwrite;
    assign restart  = wr & ((paddr == GCT_CTRL_OFS)
                    | ((paddr == GCT_CMD_OFS) & pwdata[GCT_CMD_CLR]));
    assign arm_cmd  = wr & (paddr == GCT_CMD_OFS) & pwdata[GCT_CMD_ARM];
    assign unmapped = (paddr > GCT_IMASK_OFS) | (paddr[1:0] != 2'h0);
    assign pslverr  = access & unmapped;
    assign pready   = ~wait_reg;
    assign prdata   = prdata_reg;
    assign irq      = |(istat_reg & imask_reg);

    // A result read while no result is valid holds the bus.
    assign stall = ~pwrite & (paddr == GCT_RES_OFS) & ~valid_reg
                 & (state_reg != GCT_DONE);

    always_comb
    begin
        rdata = 32'h0;
        case (paddr)
            GCT_CTRL_OFS:  rdata = {25'h0, gsel_reg, hold_reg, func_reg};
            GCT_STAT_OFS:  rdata = {28'h0, state_reg == GCT_MEAS,
                                   state_reg == GCT_ARMED, ovf_reg, valid_reg};
            GCT_RES_OFS:   rdata = res_reg;
            GCT_ISTAT_OFS: rdata = {30'h0, istat_reg};
            GCT_IMASK_OFS: rdata = {30'h0, imask_reg};
            default:       rdata = 32'h0;
        endcase
    end

    // Read data is captured in setup, or when a stalled read resolves.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata_reg <= 32'h0;
            wait_reg   <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_reg <= rdata;
            wait_reg   <= stall;
        end
        else if (wait_reg)
        begin
            prdata_reg <= rdata;
            wait_reg   <= psel & stall;
        end
    end

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            func_reg  <= GCT_FUNC_RST;
            hold_reg  <= GCT_HOLD_RST;
            gsel_reg  <= GCT_GSEL_RST;
            imask_reg <= 2'h0;
        end
        else if (wr && paddr == GCT_CTRL_OFS)
        begin
            func_reg <= (pwdata[2:0] > GCT_F_FREE) ? GCT_F_FREQ : pwdata[2:0];
            hold_reg <= pwdata[GCT_HOLD_BIT];
            gsel_reg <= (pwdata[6:4] > GCT_GSEL_MAX) ? GCT_GSEL_MAX
                      : pwdata[6:4];
        end
        else if (wr && paddr == GCT_IMASK_OFS)
        begin
            imask_reg <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Measurement datapath decisions
    // ------------------------------------------------------------
    always_comb
    begin
        case (gsel_reg)
            3'h0:    dec10 = 27'd1;
            3'h1:    dec10 = 27'd10;
            3'h2:    dec10 = 27'd100;
            3'h3:    dec10 = 27'd1000;
            default: dec10 = 27'd10000;
        endcase
    end

    assign gate_len = 32'(GATE_MIN_CYC_P * 32'(dec10));
    assign rise     = sig_in & ~sig_d_reg;
    assign fall     = ~sig_in & sig_d_reg;
    assign tick     = tmr_reg == 32'(GCT_PER_TICK_CYC - 1);
    assign lim      = (func_reg == GCT_F_PULSE) ? GCT_PW_LIM : GCT_CNT_MAX;
    assign div_r    = {rem_reg, q_reg[26]};
    assign div_ge   = div_r >= {1'b0, cnt_reg};

    always_comb
    begin
        step     = 1'b0;
        fin      = 1'b0;
        fin_mant = cnt_reg;
        fin_exp  = GCT_EXP_TOT;
        if (state_reg == GCT_MEAS)
        begin
            case (func_reg)
                GCT_F_FREQ:
                begin
                    step    = rise;
                    // Closing one count late keeps the edge of the last gate cycle.
                    fin     = tmr_reg == gate_len;
                    fin_exp = 5'(GCT_GSEL_MAX - gsel_reg);
                end
                GCT_F_AVG,
                GCT_F_GATED:
                begin
                    step = rise;
                    fin  = (func_reg == GCT_F_GATED)
                         & (tmr_reg == gate_len);
                end
                GCT_F_PER:
                begin
                    step    = tick;
                    fin     = rise;
                    fin_exp = GCT_EXP_PER;
                end
                GCT_F_PULSE:
                begin
                    step     = sig_in;
                    fin      = fall;
                    fin_mant = 27'(cnt_reg * 27'(GCT_CLK_NS));
                    fin_exp  = GCT_EXP_PW;
                end
                default:
                    step = rise;
            endcase
        end
        else if (state_reg == GCT_DIV)
        begin
            fin      = (cnt_reg == 27'h0) | (dcnt_reg == GCT_DIV_LAST);
            fin_mant = (cnt_reg == 27'h0) ? 27'h0 : {q_reg[25:0], div_ge};
            fin_exp  = GCT_EXP_AVG;
        end
    end

    // Counting saturates at eight digits rather than wrapping.
    assign ovf_set = (step & (cnt_reg >= lim))
                   | ((state_reg == GCT_DIV) & (cnt_reg == 27'h0));

    // ------------------------------------------------------------
    // Measurement sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= GCT_ARMED;
            sig_d_reg <= 1'b0;
            cnt_reg   <= 27'h0;
            tmr_reg   <= 32'h0;
            q_reg     <= 27'h0;
            rem_reg   <= 27'h0;
            dcnt_reg  <= 5'h0;
        end
        else
        begin
            sig_d_reg <= sig_in;
            if (restart)
            begin
                state_reg <= GCT_ARMED;
                cnt_reg   <= 27'h0;
                tmr_reg   <= 32'h0;
            end
            else
            begin
                case (state_reg)
                    GCT_ARMED:
                    begin
                        if (rise)
                        begin
                            state_reg <= GCT_MEAS;
                            tmr_reg   <= 32'h0;
                            cnt_reg   <= (func_reg >= GCT_F_PULSE) ? 27'h1 : 27'h0;
                        end
                    end
                    GCT_MEAS:
                    begin
                        tmr_reg <= (func_reg == GCT_F_PER && tick) ? 32'h0
                                 : tmr_reg + 32'h1;
                        if (step && cnt_reg < lim)
                            cnt_reg <= cnt_reg + 27'h1;
                        if (fin)
                            state_reg <= GCT_DONE;
                        else if (func_reg == GCT_F_AVG
                                 && tmr_reg == gate_len - 32'h1)
                        begin
                            state_reg <= GCT_DIV;
                            q_reg     <= 27'(dec10 * GCT_AVG_SCALE);
                            rem_reg   <= 27'h0;
                            dcnt_reg  <= 5'h0;
                        end
                    end
                    GCT_DIV:
                    begin
                        q_reg    <= {q_reg[25:0], div_ge};
                        rem_reg  <= div_ge ? 27'(div_r - {1'b0, cnt_reg})
                                           : div_r[26:0];
                        dcnt_reg <= dcnt_reg + 5'h1;
                        if (fin)
                            state_reg <= GCT_DONE;
                    end
                    GCT_DONE:
                    begin
                        if (arm_cmd
                            || (!hold_reg && func_reg != GCT_F_GATED))
                            state_reg <= GCT_ARMED;
                    end
                    default:
                        state_reg <= GCT_ARMED;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Result, overflow and interrupt status
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            res_reg   <= 32'h0;
            valid_reg <= 1'b0;
            ovf_reg   <= 1'b0;
        end
        else if (restart)
        begin
            res_reg   <= 32'h0;
            valid_reg <= 1'b0;
            ovf_reg   <= 1'b0;
        end
        else
        begin
            if (fin)
            begin
                res_reg   <= {fin_exp, fin_mant};
                valid_reg <= 1'b1;
            end
            else if (state_reg == GCT_MEAS && func_reg == GCT_F_FREE)
            begin
                res_reg   <= {GCT_EXP_TOT, cnt_reg};
                valid_reg <= 1'b1;
            end
            if (ovf_set)
                ovf_reg <= 1'b1;
        end
    end

    assign evt[GCT_IRQ_DONE] = fin;
    assign evt[GCT_IRQ_OVF]  = ovf_set & ~ovf_reg;

    // A new event in the same cycle as its clear keeps the bit set.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            istat_reg <= 2'h0;
        else if (wr && paddr == GCT_ISTAT_OFS)
            istat_reg <= (istat_reg & ~pwdata[1:0]) | evt;
        else
            istat_reg <= istat_reg | evt;
    end

endmodule

// ===== verification/gct_properties.sv
// Concurrent checks on the counter/timer bus and interrupt pins.
module gct_properties
    import gct_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Signal and interrupt
    input wire logic        sig_in,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    ready_zero_wait_a: assert property (
        psel && penable && (pwrite || paddr != GCT_RES_OFS) |-> pready)
        else $error("access other than result read waited");
    restart_stall_a: assert property (
        psel && penable && pready && pwrite && paddr == GCT_CTRL_OFS
        && pwdata[2:0] == GCT_F_FREQ ##2 psel && !penable && !pwrite
        && paddr == GCT_RES_OFS |=> !pready)
        else $error("result read after restart not stalled");
    unmapped_err_a: assert property (
        psel && penable && (paddr > GCT_IMASK_OFS || paddr[1:0] != 2'h0)
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (
        psel && penable && paddr <= GCT_IMASK_OFS && paddr[1:0] == 2'h0
        |-> !pslverr)
        else $error("mapped access refused");
    cmd_read_zero_a: assert property (
        psel && penable && !pwrite && paddr == GCT_CMD_OFS |-> prdata == 32'h0)
        else $error("command register read not zero");
    reset_idle_a: assert property ($rose(resetn) |-> pready && !irq)
        else $error("bus or interrupt busy after reset");
    mask_quiet_a: assert property (
        psel && penable && pready && pwrite && paddr == GCT_IMASK_OFS
        && pwdata[1:0] == 2'h0 |=> !irq [*3])
        else $error("interrupt high with all masked");
    func_clamp_a: assert property (
        psel && penable && pready && pwrite && paddr == GCT_CTRL_OFS
        && pwdata[2:0] > 3'h5 ##2 psel && !pwrite && paddr == GCT_CTRL_OFS
        |=> prdata[2:0] == GCT_F_FREQ)
        else $error("bad function code not folded to frequency");
endmodule

bind gct_top gct_properties gct_properties_i (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sig_in(sig_in), .irq(irq));

// ===== verification/gct_sig_src.sv
// Behavioural source of the signal under measurement.
module gct_sig_src (
    // Clock
    input  wire logic        sys_clk,
    // Pattern control
    input  wire logic        run,
    input  wire logic [15:0] per,
    input  wire logic [15:0] hi,
    // Measured signal
    output logic             sig_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ph_reg;

    // Phase restarts at zero on run, so one period of run is one pulse.
    always_ff @(posedge sys_clk)
    begin
        if (!run || ph_reg >= per - 16'h1)
            ph_reg <= 16'h0;
        else
            ph_reg <= ph_reg + 16'h1;
    end
    // A shorter period cuts the phase back at once instead of wrapping late.
    // Periods stay inside each gate, except the one gate starved on purpose.
    assign sig_in = run && (ph_reg < hi);
endmodule

// ===== verification/test_gated_counter_timer.sv
// Self-checking testbench for the gated counter/timer.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %0h, expected %0h", $time, (g), (e)); end end
module test_gated_counter_timer
    import gct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sig_in;
    logic        irq;
    logic        run = 1'b0;
    logic [15:0] per = 16'h8;
    logic [15:0] hi = 16'h4;
    logic [31:0] rd;
    logic [31:0] r1;
    logic        er;
    int          n_fail = 0;
    int          checks = 0;

    // Gate is 10 * 10^g cycles so that every scenario stays short.
    gct_top #(.GATE_MIN_CYC_P(10)) gct_top_i (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sig_in(sig_in), .irq(irq));
    gct_sig_src gct_sig_src_i (
        .sys_clk(sys_clk), .run(run), .per(per), .hi(hi), .sig_in(sig_in));

    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; a stalled read is waited out, never assumed.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wirq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000)
        begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(irq, 1'b1)
    endtask

    task automatic sig(input logic [15:0] p, input logic [15:0] h);
        per <= p;
        hi <= h;
        run <= 1'b1;
    endtask

    task automatic t_regs;
        apb(0, GCT_CTRL_OFS, 0);
        `CHK(rd, 32'h40)
        apb(0, GCT_IMASK_OFS, 0);
        `CHK(rd, 32'h0)
        apb(0, 8'h18, 0);
        `CHK({er, rd}, 33'h100000000)
        apb(1, GCT_CTRL_OFS, 32'h7);
        apb(0, GCT_CTRL_OFS, 0);
        `CHK(rd[2:0], GCT_F_FREQ)
        apb(0, GCT_CMD_OFS, 0);
        `CHK(rd, 32'h0)
    endtask

    task automatic t_freq;
        sig(16'h8, 16'h4);
        apb(1, GCT_CTRL_OFS, 32'h18);
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd, 32'h1800000c)
        apb(0, GCT_STAT_OFS, 0);
        `CHK(rd[2:0], 3'h1)
        apb(1, GCT_CMD_OFS, 32'h2);
        apb(0, GCT_STAT_OFS, 0);
        `CHK(rd[3] | rd[2], 1'b1)
        apb(1, GCT_ISTAT_OFS, 32'h3);
        apb(1, GCT_IMASK_OFS, 32'h1);
        apb(1, GCT_CTRL_OFS, 32'h10);
        wirq();
        apb(1, GCT_ISTAT_OFS, 32'h1);
        @(posedge sys_clk);
        `CHK(irq, 1'b0)
        wirq();
        apb(1, GCT_IMASK_OFS, 32'h0);
    endtask

    task automatic t_time;
        sig(16'd250, 16'd125);
        apb(1, GCT_CTRL_OFS, 32'h19);
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd[31:27], GCT_EXP_PER)
        `CHK(rd[26:0] >= 9 && rd[26:0] <= 11, 1'b1)
        sig(16'd200, 16'd20);
        apb(1, GCT_CTRL_OFS, 32'h1b);
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd[31:27], GCT_EXP_PW)
        `CHK(rd[26:0] >= 76 && rd[26:0] <= 84, 1'b1)
        // Period 4 in a 100 cycle gate: 25 edges, 10^5 / 25 = 4000.
        sig(16'h4, 16'h2);
        apb(1, GCT_CTRL_OFS, 32'h1a);
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd, 32'hc0000fa0)
    endtask

    task automatic t_total;
        sig(16'h4, 16'h2);
        apb(1, GCT_CTRL_OFS, 32'h4);
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd, 32'h3)
        repeat (60) @(posedge sys_clk);
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd, 32'h3)
        apb(1, GCT_CMD_OFS, 32'h1);
        apb(0, GCT_STAT_OFS, 0);
        `CHK(rd[0], 1'b0)
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd, 32'h3)
        apb(1, GCT_CTRL_OFS, 32'h5);
        repeat (60) @(posedge sys_clk);
        apb(0, GCT_RES_OFS, 0);
        r1 = rd;
        repeat (40) @(posedge sys_clk);
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd[26:0] > r1[26:0] && rd[31:27] == 5'h0, 1'b1)
    endtask

    task automatic t_ovf;
        apb(1, GCT_ISTAT_OFS, 32'h3);
        apb(1, GCT_IMASK_OFS, 32'h2);
        run <= 1'b0;
        apb(1, GCT_CTRL_OFS, 32'ha);
        sig(16'h10, 16'h8);
        repeat (16) @(posedge sys_clk);
        run <= 1'b0;
        apb(0, GCT_RES_OFS, 0);
        `CHK(rd[26:0], 27'h0)
        apb(0, GCT_STAT_OFS, 0);
        `CHK(rd[1], 1'b1)
        `CHK(irq, 1'b1)
        apb(1, GCT_ISTAT_OFS, 32'h2);
        @(posedge sys_clk);
        `CHK(irq, 1'b0)
        apb(0, GCT_STAT_OFS, 0);
        `CHK(rd[1], 1'b1)
        apb(1, GCT_CTRL_OFS, 32'ha);
        apb(0, GCT_STAT_OFS, 0);
        `CHK(rd[1], 1'b0)
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs();
        t_freq();
        t_time();
        t_total();
        t_ovf();
        end_sim();
    end

    initial
    begin
        #80000;
        n_fail++;
        end_sim();
    end
endmodule
